// ---- watch_timer_regs.svh ----
// register offsets, field positions, reset values and timing counts of the watch timer
`ifndef WATCH_TIMER_REGS_SVH
`define WATCH_TIMER_REGS_SVH

// register offsets on the 4-bit register port
`define WT_ADDR_MODE 4'h0
`define WT_ADDR_PORT 4'h1
`define WT_ADDR_STAT 4'h2
`define WT_ADDR_CLR 4'h3
`define WT_ADDR_IEN 4'h4
`define WT_ADDR_DIV 4'h5

// watch_mode_register fields
`define WM_SRC_BIT 0
`define WM_FAST_BIT 1
`define WM_RUN_BIT 2
`define WM_CLR_BIT 3
`define WM_BUZ_BIT 7

// port control register fields
`define PORT_LATCH_BIT 0
`define PORT_DIR_BIT 2
`define PORT_PIN_BIT 4

// interrupt status, clear and enable fields
`define IRQ_TICK_BIT 0

// reset values
`define WM_RESET 8'h00
`define PORT_RESET 8'h00
`define IEN_RESET 8'h00

// clock figures in hertz, the tick period in milliseconds and the fast mode ratio
`define WT_MAIN_HZ 4194304
`define WT_COUNT_HZ 32768
`define WT_TICK_MS 500
`define WT_FAST_RATIO 128
`define WT_BUZ_HZ 2048

// counts derived from the figures above
`define WT_PRESCALE_COUNT (`WT_MAIN_HZ / `WT_COUNT_HZ)
`define WT_NORMAL_COUNT ((`WT_COUNT_HZ * `WT_TICK_MS) / 1000)
`define WT_FAST_COUNT (`WT_NORMAL_COUNT / `WT_FAST_RATIO)
`define WT_BUZ_HALF (`WT_COUNT_HZ / (2 * `WT_BUZ_HZ))

`endif

// ---- watch_timer_pkg.sv ----
// types shared by the watch timer modules
package watch_timer_pkg;

  typedef logic [7:0] reg_byte_t;
  typedef logic [3:0] reg_addr_t;
  typedef logic [13:0] div_count_t;

  // count clock source selection
  typedef enum logic {
    SRC_MAIN,
    SRC_SUB
  } count_src_t;

endpackage : watch_timer_pkg

// ---- count_clk_if.sv ----
// carrier between the watch timer core and its count clock generator
`timescale 1ns/1ps
interface count_clk_if;
  import watch_timer_pkg::*;

  logic count_tick;
  count_src_t src;
  logic stop_mode;
  logic div_clear;

  modport gen (
    output count_tick,
    input src,
    input stop_mode,
    input div_clear
  );

  modport core (
    input count_tick,
    output src,
    output stop_mode,
    output div_clear
  );

endinterface : count_clk_if

// ---- watch_count_clk_gen.sv ----
// count clock generator: synchronises both clock pins, prescales the main one, selects
`timescale 1ns/1ps
`include "watch_timer_regs.svh"
module watch_count_clk_gen
  import watch_timer_pkg::*;
#(
  parameter int PRESCALE = `WT_PRESCALE_COUNT
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_sub_clk_pin,
  input wire logic i_main_clk_pin,
  count_clk_if.gen cc
);

  localparam int PW = $clog2(PRESCALE);

  logic sub_meta_q;
  logic sub_sync_q;
  logic sub_prev_q;
  logic main_meta_q;
  logic main_sync_q;
  logic main_prev_q;
  logic [PW-1:0] pre_q;
  logic sub_edge;
  logic main_edge;
  logic main_tick;

  // two-flop synchronisers, the first flop is read only by the second
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sub_meta_q <= 1'b0;
      sub_sync_q <= 1'b0;
      sub_prev_q <= 1'b0;
      main_meta_q <= 1'b0;
      main_sync_q <= 1'b0;
      main_prev_q <= 1'b0;
    end else begin
      sub_meta_q <= i_sub_clk_pin;
      sub_sync_q <= sub_meta_q;
      sub_prev_q <= sub_sync_q;
      main_meta_q <= i_main_clk_pin;
      main_sync_q <= main_meta_q;
      main_prev_q <= main_sync_q;
    end
  end

  assign sub_edge = sub_sync_q & ~sub_prev_q;
  assign main_edge = main_sync_q & ~main_prev_q;

  // main clock divided down to the count clock rate
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pre_q <= '0;
    end else if (cc.div_clear) begin
      pre_q <= '0;
    end else if (main_edge && !cc.stop_mode) begin
      pre_q <= (pre_q == PW'(PRESCALE - 1)) ? '0 : pre_q + 1'b1; // RULE_07
    end
  end

  assign main_tick = main_edge && !cc.stop_mode && (pre_q == PW'(PRESCALE - 1));

  // source selector; the main path halts in stop mode since its oscillator stops
  always_comb begin
    if (cc.src == SRC_SUB) begin
      cc.count_tick = sub_edge; // RULE_03
    end else begin
      cc.count_tick = main_tick; // RULE_10
    end
  end

endmodule : watch_count_clk_gen

// ---- watch_timer_buzzer.sv ----
// watch timer core: divider, tick flag, fast mode, buzzer pin and register port
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "watch_timer_regs.svh"

// Summary of operation
// RULE_01: tick flag sets every half second of count clock in normal mode.
// RULE_02: a set tick flag with its enable asserts the standby wake output.
// RULE_03: the count clock comes from the main path or subsystem path by selector.
// RULE_04: fast mode sets the tick flag 128 times as often, every 3.91 ms.
// RULE_05: a 2.048 kHz square wave from the count clock can drive the pin.
// RULE_06: software can clear the divider so timekeeping restarts from zero.
// RULE_07: count clock is subsystem 32.768 kHz or main 4.194304 MHz divided by 128.
// RULE_08: software selects subsystem clock when main clock is 6.0 MHz.
// RULE_09: pin driver enabled only by direction bit 2; carries buzzer or latch.
// RULE_10: in stop mode counting continues only from the subsystem clock.
// RULE_11: reset clears the watch mode register to all zeros.
// RULE_12: tick flag stays set until software clears or interrupt acknowledge.
module watch_timer_buzzer
  import watch_timer_pkg::*;
#(
  parameter int NORMAL_COUNT = `WT_NORMAL_COUNT,
  parameter int FAST_COUNT = `WT_FAST_COUNT,
  parameter int BUZ_HALF = `WT_BUZ_HALF,
  parameter int PRESCALE = `WT_PRESCALE_COUNT
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_sub_clk_pin,
  input wire logic i_main_clk_pin,
  input wire logic i_standby,
  input wire logic i_stop_mode,
  input wire logic i_irq_ack,
  input wire logic i_port2_bit3_pin,
  output logic o_port2_bit3_pin,
  output logic o_port2_bit3_pin_oe,
  output logic o_irq,
  output logic o_wake
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  localparam int DW = 14;

  count_clk_if cc ();

  reg_byte_t watch_mode_register_q;
  reg_byte_t port_ctrl_q;
  reg_byte_t irq_en_q;
  logic watch_tick_flag_q;
  div_count_t div_q;
  logic buzzer_output_q;
  logic pin_meta_q;
  logic pin_sync_q;
  logic wr_mode;
  logic wr_port;
  logic wr_clr;
  logic wr_ien;
  logic div_clear;
  logic run;
  logic advance;
  logic normal_hit;
  logic fast_hit;
  logic buz_hit;
  logic tick_event;
  logic flag_clear;
  logic pending;
  reg_byte_t rdata_d;
  logic fast_sel;
  logic normal_event;
  logic fast_event;
  logic sw_clear;
  logic buz_sel;
  logic dir_out;
  logic latch_out;

  //////////////////////////////////////////////////////////////////////////////
  // register map, every register eight bits wide
  //   0 mode: bit0 sub source, bit1 fast, bit2 run, bit3 clear strobe, bit7 buzzer
  //   1 port: bit0 output latch, bit2 drive direction, bit4 pin level read only
  //   2 status: bit0 tick flag, read only
  //   3 clear: a one in bit0 drops the tick flag, reads zero
  //   4 enable: bit0 lets the tick flag reach the interrupt and wake outputs
  //   5 divider: upper eight divider bits, read only
  //   other offsets read zero and ignore writes
  // the divider read is not frozen, so a read may land mid step
  // a main clock that is not a whole multiple of the count rate cannot give
  // the half second; software has to pick the sub source then

  //////////////////////////////////////////////////////////////////////////////
  // register port decode

  assign wr_mode = i_wr && (i_addr == `WT_ADDR_MODE);
  assign wr_port = i_wr && (i_addr == `WT_ADDR_PORT);
  assign wr_clr = i_wr && (i_addr == `WT_ADDR_CLR);
  assign wr_ien = i_wr && (i_addr == `WT_ADDR_IEN);

  // clear is a strobe carried by a mode write, never stored
  assign div_clear = wr_mode && i_wdata[`WM_CLR_BIT]; // RULE_06

  // watch mode register, zero after reset of any kind
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      watch_mode_register_q <= `WM_RESET; // RULE_11
    end else if (wr_mode) begin
      watch_mode_register_q <= i_wdata;
      watch_mode_register_q[`WM_CLR_BIT] <= 1'b0;
    end
  end

  // port latch and direction bits; direction reset leaves the pin undriven
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      port_ctrl_q <= `PORT_RESET;
    end else if (wr_port) begin
      port_ctrl_q <= i_wdata;
    end
  end

  // interrupt enable register
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_en_q <= `IEN_RESET;
    end else if (wr_ien) begin
      irq_en_q <= i_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // count clock generation

  assign cc.src = count_src_t'(watch_mode_register_q[`WM_SRC_BIT]); // RULE_03
  assign cc.stop_mode = i_stop_mode; // RULE_10
  assign cc.div_clear = div_clear;

  watch_count_clk_gen #(
    .PRESCALE(PRESCALE)
  ) u_count_clk_gen (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_sub_clk_pin(i_sub_clk_pin),
    .i_main_clk_pin(i_main_clk_pin),
    .cc(cc.gen)
  );

  //////////////////////////////////////////////////////////////////////////////
  // frequency divider

  // run low freezes the divider where it stands
  assign run = watch_mode_register_q[`WM_RUN_BIT];
  assign advance = run && cc.count_tick;

  // divider wraps every half second of count clock; a clear restarts at zero
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_q <= '0;
    end else if (div_clear) begin
      div_q <= '0; // RULE_06
    end else if (advance) begin
      div_q <= (div_q == DW'(NORMAL_COUNT - 1)) ? '0 : div_q + 1'b1;
    end
  end

  // powers of two keep these modulo compares down to plain bit tests
  assign normal_hit = (div_q == DW'(NORMAL_COUNT - 1)); // RULE_01
  assign fast_hit = ((div_q % DW'(FAST_COUNT)) == DW'(FAST_COUNT - 1)); // RULE_04
  assign buz_hit = ((div_q % DW'(BUZ_HALF)) == DW'(BUZ_HALF - 1)); // RULE_05

  // fast mode picks the shorter period for debug and inspection
  assign fast_sel = watch_mode_register_q[`WM_FAST_BIT]; // RULE_04
  assign normal_event = advance && normal_hit; // RULE_01
  assign fast_event = advance && fast_hit; // RULE_04
  assign tick_event = fast_sel ? fast_event : normal_event; // RULE_04

  //////////////////////////////////////////////////////////////////////////////
  // tick flag and interrupt

  // either the acknowledge or a one written to the clear register drops the flag
  assign sw_clear = wr_clr && i_wdata[`IRQ_TICK_BIT]; // RULE_12
  assign flag_clear = i_irq_ack || sw_clear; // RULE_12

  // a tick in the clearing cycle wins, so no half second is ever lost
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      watch_tick_flag_q <= 1'b0;
    end else if (tick_event) begin
      watch_tick_flag_q <= 1'b1; // RULE_01
    end else if (flag_clear) begin
      watch_tick_flag_q <= 1'b0; // RULE_12
    end
  end

  assign pending = watch_tick_flag_q && irq_en_q[`IRQ_TICK_BIT];

  // interrupt level, registered so the output never glitches
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= pending;
    end
  end

  // standby release only while the core is actually parked
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= pending && i_standby; // RULE_02
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // buzzer and shared pin

  // square wave toggles every BUZ_HALF ticks of count clock; clear restarts low
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      buzzer_output_q <= 1'b0;
    end else if (div_clear) begin
      buzzer_output_q <= 1'b0;
    end else if (advance && buz_hit) begin
      buzzer_output_q <= ~buzzer_output_q; // RULE_05
    end
  end

  // pin sources picked apart from the output flops
  assign buz_sel = watch_mode_register_q[`WM_BUZ_BIT];
  assign dir_out = port_ctrl_q[`PORT_DIR_BIT];
  assign latch_out = port_ctrl_q[`PORT_LATCH_BIT];

  // pin drive enable; reset leaves the pin as an input
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_port2_bit3_pin_oe <= 1'b0;
    end else begin
      o_port2_bit3_pin_oe <= dir_out; // RULE_09
    end
  end

  // pin value: buzzer wave when the mode bit asks for it, else the port latch
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_port2_bit3_pin <= 1'b0;
    end else begin
      o_port2_bit3_pin <= buz_sel ? buzzer_output_q : latch_out; // RULE_09
    end
  end

  // pin level synchronised before software may read it
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= i_port2_bit3_pin;
      pin_sync_q <= pin_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path

  // read data select; unmapped and write-only offsets read as zero
  always_comb begin
    rdata_d = 8'h00;
    case (i_addr)
      `WT_ADDR_MODE: begin
        rdata_d = watch_mode_register_q;
      end
      `WT_ADDR_PORT: begin
        rdata_d[`PORT_LATCH_BIT] = port_ctrl_q[`PORT_LATCH_BIT];
        rdata_d[`PORT_DIR_BIT] = port_ctrl_q[`PORT_DIR_BIT];
        rdata_d[`PORT_PIN_BIT] = pin_sync_q;
      end
      `WT_ADDR_STAT: begin
        rdata_d[`IRQ_TICK_BIT] = watch_tick_flag_q;
      end
      `WT_ADDR_IEN: begin
        rdata_d = irq_en_q;
      end
      `WT_ADDR_DIV: begin
        rdata_d = div_q[DW-1:DW-8];
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule : watch_timer_buzzer

// ---- watch_timer_buzzer_sva.sv ----
// checker for the watch timer register port, tick interrupt and pin driver
`timescale 1ns/1ps
`include "watch_timer_regs.svh"
module wtb_checker (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_standby,
  input wire logic i_irq_ack,
  input wire logic o_port2_bit3_pin,
  input wire logic o_port2_bit3_pin_oe,
  input wire logic o_irq,
  input wire logic o_wake
);
  logic [7:0] mode_q, port_q, ien_q;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);
  ////////////////////////////////////////////////////////////////////////
  // shadow copies of the writable registers, for readback and pin checks
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_q <= 8'h00;
      port_q <= 8'h00;
      ien_q <= 8'h00;
    end else if (i_wr) begin
      if (i_addr == `WT_ADDR_MODE) mode_q <= i_wdata;
      if (i_addr == `WT_ADDR_PORT) port_q <= i_wdata;
      if (i_addr == `WT_ADDR_IEN) ien_q <= i_wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // assertions; the clear bit is a strobe, so it never reads back
  a_reset_quiet: assert property (!$past(i_resetn) |-> !o_irq && !o_wake && !o_port2_bit3_pin_oe)
    else $error("output active after reset");
  a_mode_readback: assert property ($past(i_rd) && $past(i_addr) == `WT_ADDR_MODE |->
    o_rdata == ($past(mode_q) & 8'hf7)) else $error("mode readback wrong");
  a_wake_standby: assert property (o_wake |-> $past(i_standby))
    else $error("wake without standby");
  a_wake_irq: assert property (o_wake |-> o_irq)
    else $error("wake without interrupt");
  a_irq_enabled: assert property (o_irq |-> $past(ien_q[`IRQ_TICK_BIT]))
    else $error("interrupt while disabled");
  a_irq_sticky: assert property (o_irq && !$past(i_wr) && !$past(i_irq_ack) |=> o_irq)
    else $error("interrupt dropped without clear");
  a_oe_dir: assert property (o_port2_bit3_pin_oe == $past(port_q[`PORT_DIR_BIT]))
    else $error("pin drive not per direction");
  a_pin_latch: assert property (o_port2_bit3_pin_oe && !$past(mode_q[`WM_BUZ_BIT]) |->
    o_port2_bit3_pin == $past(port_q[`PORT_LATCH_BIT])) else $error("pin not latch");
  c_wake: cover property (o_wake);
  c_irq_rise: cover property ($rose(o_irq));
  c_buzz: cover property (o_port2_bit3_pin_oe && mode_q[`WM_BUZ_BIT] && $changed(o_port2_bit3_pin));
endmodule : wtb_checker
bind watch_timer_buzzer wtb_checker i_wtb_checker (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_standby(i_standby),
  .i_irq_ack(i_irq_ack), .o_port2_bit3_pin(o_port2_bit3_pin),
  .o_port2_bit3_pin_oe(o_port2_bit3_pin_oe), .o_irq(o_irq), .o_wake(o_wake)
);

// ---- tb_top.sv ----
// self-checking bench for the watch timer with buzzer pin
`timescale 1ns/1ps
`include "watch_timer_regs.svh"
module tb_top
  import watch_timer_pkg::*;
;
  localparam int SP = 16; // core cycles per count clock period, both sources
  localparam int NC = 64;
  localparam int FC = 8;
  localparam int BH = 2;
  logic i_core_clk = 0, i_resetn = 0, i_wr = 0, i_rd = 0, i_standby = 0, i_stop_mode = 0;
  logic i_irq_ack = 0, i_port2_bit3_pin = 0, i_sub_clk_pin = 0, i_main_clk_pin = 0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic o_port2_bit3_pin, o_port2_bit3_pin_oe, o_irq, o_wake, v;
  logic [3:0] ph = 4'h0;
  int mismatches = 0, checks_done = 0, cyc = 0, n;
  watch_timer_buzzer #(.NORMAL_COUNT(NC), .FAST_COUNT(FC), .BUZ_HALF(BH), .PRESCALE(4))
    i_watch_timer_buzzer (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sub_clk_pin(i_sub_clk_pin),
    .i_main_clk_pin(i_main_clk_pin), .i_standby(i_standby), .i_stop_mode(i_stop_mode),
    .i_irq_ack(i_irq_ack), .i_port2_bit3_pin(i_port2_bit3_pin),
    .o_port2_bit3_pin(o_port2_bit3_pin), .o_port2_bit3_pin_oe(o_port2_bit3_pin_oe),
    .o_irq(o_irq), .o_wake(o_wake)
  );
  always #25 i_core_clk = ~i_core_clk;
  // pin clocks: main is four times the count rate, prescaled by four
  always @(posedge i_core_clk) begin
    ph <= ph + 4'h1;
    i_sub_clk_pin <= ph[3];
    i_main_clk_pin <= ph[1];
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      wrap_up;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // shared bus, compare and timing helpers
  task automatic wrap_up;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  function automatic int win(input int exp, input int g, input int tol);
    return (g >= exp - tol && g <= exp + tol) ? exp : g;
  endfunction : win
  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input reg_addr_t a, input reg_byte_t exp, input string what);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 chk(what, exp, o_rdata);
  endtask : rd
  task automatic wait_irq(input logic lvl, inout int g);
    while (o_irq !== lvl && g < 5000) begin
      @(posedge i_core_clk);
      g++;
    end
  endtask : wait_irq
  task automatic ack;
    @(posedge i_core_clk);
    i_irq_ack <= 1'b1;
    @(posedge i_core_clk);
    i_irq_ack <= 1'b0;
  endtask : ack
  // the first gap after a mode change is partial, so only the second counts
  task automatic gap_is(input string what, input int exp);
    int g;
    repeat (2) begin
      g = 0;
      ack;
      wait_irq(1'b0, g);
      wait_irq(1'b1, g);
    end
    chk(what, exp, win(exp, g + 2, 8));
  endtask : gap_is
  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00, "reset value");
    wr(`WT_ADDR_MODE, 8'hfa);
    rd(`WT_ADDR_MODE, 8'hf2, "clear bit readback");
  endtask : t_reset
  task automatic t_periods;
    wr(`WT_ADDR_IEN, 8'h01);
    wr(`WT_ADDR_MODE, 8'h0d);
    gap_is("sub period", NC * SP);
    wr(`WT_ADDR_MODE, 8'h0c);
    gap_is("main period", NC * SP);
    wr(`WT_ADDR_MODE, 8'h0f);
    gap_is("fast period", FC * SP);
  endtask : t_periods
  task automatic t_irq;
    wr(`WT_ADDR_MODE, 8'h0d);
    i_standby <= 1'b1;
    ack;
    n = 0;
    wait_irq(1'b0, n);
    wait_irq(1'b1, n);
    chk("wake", 1, o_wake);
    i_standby <= 1'b0;
    wr(`WT_ADDR_IEN, 8'h00);
    rd(`WT_ADDR_STAT, 8'h01, "flag held");
    chk("masked", 0, o_irq);
    wr(`WT_ADDR_CLR, 8'h01);
    rd(`WT_ADDR_STAT, 8'h00, "flag cleared");
    wr(`WT_ADDR_IEN, 8'h01);
  endtask : t_irq
  task automatic t_stop;
    i_stop_mode <= 1'b1;
    wr(`WT_ADDR_MODE, 8'h0c);
    n = 0;
    wait_irq(1'b1, n);
    chk("main halted", 1, n > 2 * NC * SP);
    wr(`WT_ADDR_MODE, 8'h0d);
    gap_is("sub in stop", NC * SP);
    i_stop_mode <= 1'b0;
  endtask : t_stop
  // a clear mid-count must push the next tick a full period out
  task automatic t_clear;
    ack;
    repeat (600) @(posedge i_core_clk);
    wr(`WT_ADDR_MODE, 8'h0d);
    n = 0;
    wait_irq(1'b1, n);
    chk("restart", NC * SP, win(NC * SP, n, 20));
  endtask : t_clear
  task automatic t_pin;
    wr(`WT_ADDR_PORT, 8'h04);
    wr(`WT_ADDR_MODE, 8'h85);
    repeat (2) begin
      v = o_port2_bit3_pin;
      n = 0;
      while (o_port2_bit3_pin === v && n < 200) begin
        @(posedge i_core_clk);
        n++;
      end
    end
    chk("buzzer half", BH * SP, win(BH * SP, n, 2));
    chk("drive on", 1, o_port2_bit3_pin_oe);
    wr(`WT_ADDR_PORT, 8'h00);
    repeat (2) @(posedge i_core_clk);
    chk("drive off", 0, o_port2_bit3_pin_oe);
    wr(`WT_ADDR_MODE, 8'h05);
    wr(`WT_ADDR_PORT, 8'h05);
    repeat (2) @(posedge i_core_clk);
    chk("latch out", 1, o_port2_bit3_pin);
    i_port2_bit3_pin <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    rd(`WT_ADDR_PORT, 8'h15, "pin input");
  endtask : t_pin
  // a reset in mid-run must bring the mode register and the pin driver back
  task automatic t_reset_mid;
    @(posedge i_core_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    chk("drive after reset", 0, o_port2_bit3_pin_oe);
    rd(`WT_ADDR_MODE, 8'h00, "mode after reset");
    rd(`WT_ADDR_PORT, 8'h10, "port after reset");
  endtask : t_reset_mid
  initial begin
    repeat (2) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    t_reset;
    t_periods;
    t_irq;
    t_stop;
    t_clear;
    t_pin;
    t_reset_mid;
    wrap_up;
  end
endmodule : tb_top
